// [rtl/secp_pkg.sv]
package secp_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_TIMER_W = 24;

  // ************************************************************
  // Array and word geometry
  // ************************************************************
  localparam int MEM_BYTES = 512;
  localparam logic [4:0] CMD_LAST_NARROW = 5'h0a;
  localparam logic [4:0] CMD_LAST_WIDE = 5'h09;
  localparam logic [4:0] DATA_LAST_NARROW = 5'h07;
  localparam logic [4:0] DATA_LAST_WIDE = 5'h0f;
  localparam logic [1:0] SWEEP_NARROW = 2'h1;
  localparam logic [1:0] SWEEP_WIDE = 2'h2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ************************************************************
  // Opcodes and special sub-codes
  // ************************************************************
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    WIDTH_BY_PIN = 2'h0,
    WIDTH_NARROW = 2'h1,
    WIDTH_WIDE = 2'h2
  } secp_width_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_DATA = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } secp_state_type;

  typedef struct packed {
    logic cs_m, cs_s, cs_p;
    logic ck_m, ck_s, ck_p;
    logic di_m, di_s;
    logic org_m, org_s;
    secp_state_type state;
    logic [4:0] cnt;
    logic [10:0] cmd;
    logic wide;
    logic [8:0] addr;
    logic [15:0] data;
    logic all_op;
    logic prog_en;
    logic pend;
    logic busy;
    logic [PROG_TIMER_W-1:0] timer;
    logic [9:0] idx;
    logic [8:0] prog_addr;
    logic [15:0] prog_data;
    logic prog_all;
    logic prog_wide;
    logic show_st;
    logic [8:0] fptr;
    logic [1:0] bcnt;
    logic bwr, brd;
    logic [1:0][15:0] buff;
    logic [15:0] osh;
    logic [4:0] left;
    logic dout;
    logic oe_n;
  } secp_regs_type;

endpackage

// [rtl/secp_command_port.sv]
`timescale 1ns/1ps
// What this block does
// - Power up with programming disabled; erase and write ignored until enable command.
// - After enable, erase and write stay allowed until disable command or power loss.
// - Master disables after programming; reads work the same enabled or disabled.
// - Read drives one zero bit, then the addressed 8-bit or 16-bit word.
// - Read data bits change on rising serial clock edges.
// - With select held high, read continues with next words automatically.
// - Low-voltage variant: select falling after last data bit starts programming.
// - 5 V variant: clock edge sampling last data bit starts programming.
// - Select high again during programming shows busy low, then ready high.
// - Start bit then select low removes ready/busy from the output.
// - Fill-all writes its data word into every array location.
// - Fill-all erases whole array first, and needs programming enabled.
// - Programming cycle completes without any serial clock edges.
// - Select low gives standby, but a running program cycle finishes first.
// - Select low between instructions; while low, control logic is held reset.
// - Opcode, address and data sampled on rising serial clock edges.
// - Serial clock may pause at any level; transfer resumes correctly.
// - Select high with input low: clock edges change nothing while waiting.
// - Instruction runs only when complete; then inputs ignored until next start.
// - Select low through whole cycle keeps output off; later status reads high.
// - Width pin high selects 16-bit words, low 8-bit; fixed variants ignore it.
// - Start bit is first rising clock edge with select and input both high.
// - Opcodes 10 read, 01 write, 11 erase, 00 special with four sub-codes.
// - Output off except read data or status; off again when select falls.
module secp_command_port #(
  parameter secp_pkg::secp_width_type WIDTH_MODE = secp_pkg::WIDTH_BY_PIN,
  parameter bit START_ON_CLOCK = 1'b0,
  parameter int PROG_CYCLES = secp_pkg::PROG_CYCLES
) (
  input wire logic clk_in,                 // System clock, 10 MHz
  input wire logic rstn_in,                // Asynchronous reset, active low
  input wire logic select_in,              // Chip select pin
  input wire logic sclk_in,                // Serial clock pin
  input wire logic serial_in,              // Serial data input pin
  input wire logic word_width_select_in,   // High: 16-bit words
  output logic serial_out_out,             // Serial data output level
  output logic serial_oe_n_out,            // Output enable, low while driving
  output logic busy_out,                   // Programming cycle running
  output logic program_enabled_out         // Erase and write permitted
);
  import secp_pkg::*;

  // ************************************************************
  // State and array
  // ************************************************************
  secp_regs_type r;
  secp_regs_type n;
  logic [7:0] mem [MEM_BYTES];
  logic mem_we;
  logic [8:0] mem_wa;
  logic [7:0] mem_wd;
  logic [15:0] fetched;

  // Fetch port for the read prefetcher; high byte sits at the even address
  always_comb begin
    if (r.wide) begin
      fetched = {mem[{r.fptr[7:0], 1'b0}], mem[{r.fptr[7:0], 1'b1}]};
    end else begin
      fetched = {8'h00, mem[r.fptr]};
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic ck_rise;
    logic cs;
    logic wide_now;
    logic [10:0] cmd_new;
    logic [15:0] data_new;
    logic [1:0] op;
    logic [1:0] sub;
    logic [8:0] addr;
    logic can_prog;
    logic arm;
    logic start_now;
    logic push;
    logic pop;
    logic [15:0] word;
    logic [7:0] pattern;
    ck_rise = 1'b0;
    cs = 1'b0;
    wide_now = 1'b0;
    cmd_new = '0;
    data_new = '0;
    op = '0;
    sub = '0;
    addr = '0;
    can_prog = 1'b0;
    arm = 1'b0;
    start_now = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    word = '0;
    pattern = '0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    n = r;

    // Pins from the master are asynchronous to clk_in
    n.cs_m = select_in;
    n.cs_s = r.cs_m;
    n.cs_p = r.cs_s;
    n.ck_m = sclk_in;
    n.ck_s = r.ck_m;
    n.ck_p = r.ck_s;
    n.di_m = serial_in;
    n.di_s = r.di_m;
    n.org_m = word_width_select_in;
    n.org_s = r.org_m;

    // Only rising edges act, so a stalled clock at either level is harmless
    ck_rise = r.ck_s & ~r.ck_p;
    cs = r.cs_s;
    wide_now = (WIDTH_MODE == WIDTH_WIDE) ||
               ((WIDTH_MODE == WIDTH_BY_PIN) && r.org_s);
    cmd_new = {r.cmd[9:0], r.di_s};
    data_new = {r.data[14:0], r.di_s};
    if (r.wide) begin
      op = cmd_new[9:8];
      sub = cmd_new[7:6];
      addr = {1'b0, cmd_new[7:0]};
    end else begin
      op = cmd_new[10:9];
      sub = cmd_new[8:7];
      addr = cmd_new[8:0];
    end
    can_prog = r.prog_en & ~r.busy & ~r.pend;

    // ************************************************************
    // Programming cycle, runs free of select and serial clock
    // ************************************************************
    if (r.busy) begin
      if (r.prog_all) begin
        // First pass erases every byte, second writes the pattern
        pattern = (r.prog_wide && !r.idx[0]) ? r.prog_data[15:8] : r.prog_data[7:0];
        mem_we = 1'b1;
        mem_wa = r.idx[8:0];
        mem_wd = r.idx[9] ? pattern : 8'hff;
      end else begin
        mem_we = {1'b0, r.idx} < {9'h000, (r.prog_wide ? SWEEP_WIDE : SWEEP_NARROW)};
        if (r.prog_wide) begin
          mem_wa = {r.prog_addr[7:0], r.idx[0]};
          mem_wd = r.idx[0] ? r.prog_data[7:0] : r.prog_data[15:8];
        end else begin
          mem_wa = r.prog_addr;
          mem_wd = r.prog_data[7:0];
        end
      end
      if (!(&r.idx)) begin
        n.idx = r.idx + 10'h001;
      end
      n.timer = r.timer - 1'b1;
      if (r.timer == 1) begin
        n.busy = 1'b0;
      end
    end

    // ************************************************************
    // Instruction sequencer
    // ************************************************************
    if (!cs) begin
      // Deselected: sequencer held at rest, output released
      n.state = ST_IDLE;
      n.cnt = '0;
      n.oe_n = 1'b1;
      n.bcnt = '0;
      if (r.cs_p && r.pend) begin
        start_now = 1'b1;
      end
    end else if (ck_rise) begin
      case (r.state)
        ST_IDLE: begin
          if (r.di_s) begin
            n.state = ST_CMD;
            n.cnt = '0;
            n.show_st = 1'b0;
            n.wide = wide_now;
          end
        end
        ST_CMD: begin
          n.cmd = cmd_new;
          n.cnt = r.cnt + 5'h01;
          if (r.cnt == (r.wide ? CMD_LAST_WIDE : CMD_LAST_NARROW)) begin
            n.state = ST_DONE;
            n.addr = addr;
            n.all_op = 1'b0;
            n.cnt = '0;
            case (op)
              OP_READ: begin
                // Dummy zero goes out on the edge that takes the last address bit
                n.state = ST_READ;
                n.fptr = addr;
                n.bcnt = '0;
                n.bwr = 1'b0;
                n.brd = 1'b0;
                n.left = '0;
                n.dout = 1'b0;
                n.oe_n = 1'b0;
              end
              OP_WRITE: begin
                n.state = ST_DATA;
              end
              OP_ERASE: begin
                n.data = ERASED_WORD;
                arm = can_prog;
              end
              default: begin
                case (sub)
                  SUB_ENABLE: n.prog_en = 1'b1;
                  SUB_DISABLE: n.prog_en = 1'b0;
                  SUB_FILL: begin
                    n.state = ST_DATA;
                    n.all_op = 1'b1;
                  end
                  default: begin
                    n.data = ERASED_WORD;
                    n.all_op = 1'b1;
                    arm = can_prog;
                  end
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          n.data = data_new;
          n.cnt = r.cnt + 5'h01;
          if (r.cnt == (r.wide ? DATA_LAST_WIDE : DATA_LAST_NARROW)) begin
            n.state = ST_DONE;
            if (!r.wide) begin
              n.data = {8'h00, data_new[7:0]};
            end
            arm = can_prog;
          end
        end
        ST_READ: begin
          if (r.left == 0) begin
            if (r.bcnt != 2'h0) begin
              pop = 1'b1;
              word = r.buff[r.brd];
              if (!r.wide) begin
                word = {word[7:0], 8'h00};
              end
              n.dout = word[15];
              n.osh = {word[14:0], 1'b0};
              n.left = r.wide ? DATA_LAST_WIDE : DATA_LAST_NARROW;
              n.brd = ~r.brd;
            end
          end else begin
            n.dout = r.osh[15];
            n.osh = {r.osh[14:0], 1'b0};
            n.left = r.left - 5'h01;
          end
        end
        default: begin
          // Complete instruction: clock and input ignored until reselect
        end
      endcase
    end

    // Commands arm here; the start point depends on the variant
    if (arm) begin
      if (START_ON_CLOCK) begin
        start_now = 1'b1;
      end else begin
        n.pend = 1'b1;
      end
    end
    if (start_now) begin
      n.pend = 1'b0;
      n.busy = 1'b1;
      n.timer = PROG_TIMER_W'(PROG_CYCLES);
      n.idx = '0;
      n.prog_addr = arm ? n.addr : r.addr;
      n.prog_data = arm ? n.data : r.data;
      n.prog_all = arm ? n.all_op : r.all_op;
      n.prog_wide = r.wide;
      n.show_st = 1'b1;
    end

    // ************************************************************
    // Two-entry read buffer between the array and the shifter
    // ************************************************************
    // Serial clock is far slower than the fetch, so the buffer stalls full
    push = cs && (r.state == ST_READ) && (r.bcnt != 2'h2);
    if (push) begin
      n.buff[r.bwr] = fetched;
      n.bwr = ~r.bwr;
      n.fptr = r.wide ? {1'b0, r.fptr[7:0] + 8'h01} : r.fptr + 9'h001;
    end
    if (cs && (r.state == ST_READ)) begin
      n.bcnt = r.bcnt + {1'b0, push} - {1'b0, pop};
    end

    // ************************************************************
    // Ready/busy on the output between instructions
    // ************************************************************
    if (cs && (n.state == ST_IDLE) && n.show_st) begin
      n.oe_n = 1'b0;
      n.dout = ~n.busy;
    end else if (n.state != ST_READ) begin
      n.oe_n = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.oe_n <= 1'b1;
      r.prog_en <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // The array keeps no reset, like the cells it stands for
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign serial_out_out = r.dout;
  assign serial_oe_n_out = r.oe_n;
  assign busy_out = r.busy;
  assign program_enabled_out = r.prog_en;

endmodule

// [bench/secp_command_port_checker.sv]
`timescale 1ns/1ps
module secp_command_port_checker #(
  parameter int PROG_CYCLES = 2000,
  parameter bit START_ON_CLOCK = 1'b0
) (
  input wire logic clk_in,               // Clock
  input wire logic rstn_in,              // Reset
  input wire logic select_in,            // Select pin
  input wire logic sclk_in,              // Serial clock pin
  input wire logic serial_in,            // Serial data in
  input wire logic word_width_select_in, // Width pin
  input wire logic serial_out_out,       // Data out
  input wire logic serial_oe_n_out,      // Output enable
  input wire logic busy_out,             // Busy
  input wire logic program_enabled_out   // Enabled
);
  // ****
  // Busy length
  // ****
  logic [23:0] cnt_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 24'h0;
    end else begin
      cnt_r <= busy_out ? cnt_r + 24'h1 : 24'h0;
    end
  end
  property p_oe_desel;
    !select_in [*5] |-> serial_oe_n_out;
  endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("output driven while deselected");
  property p_oe_on;
    $fell(serial_oe_n_out) |-> $past(select_in, 2);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output enabled without select");
  property p_en_change;
    $changed(program_enabled_out) |-> $past(select_in, 3);
  endproperty
  a_en_change: assert property (p_en_change) else $error("enable moved while idle");
  property p_busy_start;
    $rose(busy_out) |-> program_enabled_out &&
      (START_ON_CLOCK ? $past(select_in) : !$past(select_in));
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("bad cycle start");
  property p_busy_len;
    $fell(busy_out) |-> cnt_r >= PROG_CYCLES - 1 && cnt_r <= PROG_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_low;
    busy_out && $past(busy_out, 2) && !serial_oe_n_out |-> !serial_out_out;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("status high while busy");
  property p_ready;
    $fell(busy_out) |-> ##[0:3] (serial_oe_n_out || serial_out_out);
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown");
  property p_dout_sclk;
    $changed(serial_out_out) && !serial_oe_n_out && !$past(serial_oe_n_out) && select_in
      && !$past(busy_out, 2) |-> $past(sclk_in, 3) || $past(sclk_in, 4) || $past(sclk_in, 5);
  endproperty
  a_dout_sclk: assert property (p_dout_sclk) else $error("data moved off clock");
endmodule

bind secp_command_port secp_command_port_checker #(.PROG_CYCLES(PROG_CYCLES),
  .START_ON_CLOCK(START_ON_CLOCK)) u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .select_in(select_in), .sclk_in(sclk_in),
  .serial_in(serial_in), .word_width_select_in(word_width_select_in),
  .serial_out_out(serial_out_out), .serial_oe_n_out(serial_oe_n_out),
  .busy_out(busy_out), .program_enabled_out(program_enabled_out));

// [bench/secp_host_model.sv]
`timescale 1ns/1ps
module secp_host_model (
  input wire logic clk_in,   // Clock
  input wire logic sdo_in,   // Device data out
  input wire logic oe_n_in,  // Device output enable
  output logic select_out,   // Select pin
  output logic sclk_out,     // Serial clock
  output logic sdi_out       // Serial data
);
  // ****
  // Serial master
  // ****
  logic last_r = 1'b0;
  logic line;
  initial begin
    select_out = 1'b0;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // A released line does not keep its last level
  always @(posedge clk_in) if (!oe_n_in) last_r <= sdo_in;
  assign line = oe_n_in ? ~last_r : sdo_in;
  task automatic frame(input logic [31:0] bits, input int n, input int nrd, input int pause,
                       output logic [63:0] rd);
    rd = '0;
    @(negedge clk_in) select_out = 1'b1;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < n + nrd; i++) begin
      sdi_out = (i < n) ? bits[n-1-i] : 1'b0;
      repeat (2) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4 + ((i == 5) ? pause : 0)) @(negedge clk_in);
      sclk_out = 1'b0;
      repeat (2) @(negedge clk_in);
      if (i >= n - 1) rd = {rd[62:0], line};
    end
    repeat (4) @(negedge clk_in);
    select_out = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  task automatic status(output logic oe_n, output logic v);
    select_out = 1'b1;
    repeat (8) @(negedge clk_in);
    oe_n = oe_n_in;
    v = line;
    select_out = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
endmodule

// [bench/secp_command_port_tb.sv]
`timescale 1ns/1ps
module secp_command_port_tb;
  import secp_pkg::*;
  // ****
  // Bench
  // ****
  localparam int PC = 2000;
  logic clk_in = 1'b0;
  logic rstn_in, wsel, sdo, oe_n, busy, pen, sel, sclk, sdi, o, v;
  logic busy2;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] mem [512];
  logic [31:0] seed = 32'h5082;
  logic [63:0] rd;
  always #50 clk_in = ~clk_in;
  secp_command_port #(.WIDTH_MODE(WIDTH_BY_PIN), .START_ON_CLOCK(1'b0), .PROG_CYCLES(PC)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .select_in(sel), .sclk_in(sclk), .serial_in(sdi),
    .word_width_select_in(wsel), .serial_out_out(sdo), .serial_oe_n_out(oe_n),
    .busy_out(busy), .program_enabled_out(pen));
  // Second copy starts its cycles on the clock edge of the last bit
  secp_command_port #(.WIDTH_MODE(WIDTH_BY_PIN), .START_ON_CLOCK(1'b1),
    .PROG_CYCLES(PC)) dut_clk (
    .clk_in(clk_in), .rstn_in(rstn_in), .select_in(sel), .sclk_in(sclk), .serial_in(sdi),
    .word_width_select_in(wsel), .serial_out_out(), .serial_oe_n_out(),
    .busy_out(busy2), .program_enabled_out());
  secp_host_model host (.clk_in(clk_in), .sdo_in(sdo), .oe_n_in(oe_n), .select_out(sel),
    .sclk_out(sclk), .sdi_out(sdi));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_word(input bit w, input int wa);
    return w ? {mem[(2 * wa) % 512], mem[(2 * wa + 1) % 512]} : {8'h00, mem[wa % 512]};
  endfunction
  task automatic chk_flag(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge busy) chk_flag("start after select fall", 1'b0, sel);
  always @(posedge busy2) chk_flag("start before select fall", 1'b1, sel);
  task automatic run(input bit w, input logic [1:0] op, input logic [8:0] a,
                     input logic [15:0] d, input int nrd, input int pause);
    logic [31:0] c;
    int n;
    c = w ? {21'h0, 1'b1, op, a[7:0]} : {20'h0, 1'b1, op, a};
    n = w ? 11 : 12;
    if (op == OP_WRITE || (op == OP_SPECIAL && a[8:7] == SUB_FILL && !w)) begin
      c = w ? {c[15:0], d} : {c[23:0], d[7:0]};
      n = n + (w ? 16 : 8);
    end
    wsel = w;
    host.frame(c, n, nrd, pause, rd);
  endtask
  task automatic spec(input logic [1:0] sub, input logic [15:0] d);
    run(1'b0, OP_SPECIAL, {sub, 7'h0}, d, 0, 0);
  endtask
  task automatic rd_chk(input bit w, input logic [8:0] a, input int words, input int pause);
    int ws;
    int base;
    ws = w ? 16 : 8;
    base = w ? a[7:0] : a;
    run(w, OP_READ, a, 16'h0, words * ws, pause);
    chk_flag("dummy bit", 1'b0, rd[words * ws]);
    for (int k = 0; k < words; k++) begin
      chk_word("read word", exp_word(w, base + k),
               16'((rd >> ((words - 1 - k) * ws)) & ((64'h1 << ws) - 1)));
    end
  endtask
  task automatic wait_prog(input bit peek);
    int t;
    t = 0;
    chk_flag("busy start", 1'b1, busy);
    chk_flag("busy start clocked", 1'b1, busy2);
    if (peek) begin
      host.status(o, v);
      chk_flag("busy oe", 1'b0, o);
      chk_flag("busy status", 1'b0, v);
    end
    while (busy !== 1'b0 && t < PC + 100) begin
      @(negedge clk_in);
      t++;
    end
    chk_flag("busy end", 1'b0, busy);
    host.status(o, v);
    chk_flag("ready oe", 1'b0, o);
    chk_flag("ready", 1'b1, v);
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    final_report();
  end
  initial begin
    rstn_in = 1'b0;
    wsel = 1'b0;
    repeat (6) @(negedge clk_in);
    rstn_in = 1'b1;
    chk_flag("enabled", 1'b0, pen);
    chk_flag("oe_n", 1'b1, oe_n);
    repeat (3) @(negedge clk_in);
    spec(SUB_FILL, 16'h005a);
    chk_flag("busy", 1'b0, busy);
    host.frame(32'h980, 15, 0, 0, rd);
    chk_flag("enabled", 1'b1, pen);
    seed = lfsr(seed);
    spec(SUB_FILL, seed[15:0]);
    foreach (mem[i]) mem[i] = seed[7:0];
    wait_prog(1'b1);
    host.frame(32'h1, 1, 0, 0, rd);
    host.status(o, v);
    chk_flag("status removed", 1'b1, o);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      run(seed[20], (i == 2) ? OP_ERASE : OP_WRITE, seed[8:0], seed[31:16], 0, 0);
      if (seed[20]) begin
        mem[{seed[7:0], 1'b0}] = (i == 2) ? 8'hff : seed[31:24];
        mem[{seed[7:0], 1'b1}] = (i == 2) ? 8'hff : seed[23:16];
      end else begin
        mem[seed[8:0]] = (i == 2) ? 8'hff : seed[23:16];
      end
      wait_prog(1'b0);
      rd_chk(seed[20], seed[8:0], 1, 0);
    end
    rd_chk(1'b0, 9'h1fe, 3, 0);
    rd_chk(1'b1, seed[8:0], 2, 20);
    host.frame({8'h0, 12'h800, 12'h980}, 24, 0, 0, rd);
    chk_flag("enabled", 1'b0, pen);
    run(1'b0, OP_WRITE, 9'h1fe, ~seed[15:0], 0, 0);
    chk_flag("busy", 1'b0, busy);
    rd_chk(1'b0, 9'h1fe, 1, 0);
    spec(SUB_ENABLE, 16'h0);
    spec(SUB_CLEAR, 16'h0);
    foreach (mem[i]) mem[i] = 8'hff;
    wait_prog(1'b0);
    rd_chk(1'b1, seed[24:16], 1, 0);
    spec(SUB_DISABLE, 16'h0);
    chk_flag("enabled", 1'b0, pen);
    final_report();
  end
endmodule
